// ### rtl/port_pin_reset.sv
// Port with reset-time pull-downs, shared reset pin and
// external-interrupt-shared bits, reached over APB.
// Assumes an option byte that is stable once nrst is released.
`timescale 1ns/100ps

// Functional notes
// - While in reset the two oscillator/analog shared pins are pulled low.
// - The option byte makes the shared reset pin either a reset or a port.
// - Option read waits after release; a low reset pin keeps reset held.
// - An output-mode level change on an interrupt pin sets its flag.
// - A single-bit port write is a whole-byte read-modify-write.
module port_pin_reset
(
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [port_pin_pkg::ADDR_W-1:0] paddr,
  input  wire logic [port_pin_pkg::DATA_W-1:0] pwdata,
  output logic      [port_pin_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [port_pin_pkg::PORT_W-1:0] padIn,
  output logic      [port_pin_pkg::PORT_W-1:0] padOut,
  output logic      [port_pin_pkg::PORT_W-1:0] padOe,
  input  wire logic                      reset_shared_port_pin,
  input  wire logic [7:0]                optionByte,
  output logic                           osc_out_analog_shared_pin_pd,
  output logic                           osc_in_analog_shared_pin_pd,
  output logic                           coreRstN,
  output logic      [1:0]                irqRequest
);
  import port_pin_pkg::*;

  typedef enum logic [1:0] {ST_HOLD, ST_OPT, ST_RUN} run_state_e;
  run_state_e        state_q;
  logic [3:0]        optCnt_q;
  logic              optIsReset_q;
  logic [PORT_W-1:0] latch_q;
  logic [PORT_W-1:0] mode_q;
  logic [1:0]        flag_q;
  logic [1:0]        mask_q;
  logic [1:0]        prevLvl_q;
  logic [PORT_W:0]   syncAll;
  logic [PORT_W-1:0] pinSync;
  logic              rstPinSync;
  logic              running;
  logic              access;
  logic              wrEn;
  logic              mapped;
  logic [PORT_W-1:0] portView;
  logic [PORT_W-1:0] rmwByte;
  logic [2:0]        bitIdx;
  logic [1:0]        effLvl;
  logic [1:0]        irqEdge;
  logic [1:0]        flagClr;
  logic [DATA_W-1:0] rdMux;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  port_pin_sync #(.W(PORT_W + 1)) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .asyncIn ({reset_shared_port_pin, padIn}),
    .syncOut (syncAll)
  );

  assign pinSync    = syncAll[PORT_W-1:0];
  assign rstPinSync = syncAll[PORT_W];
  assign running    = (state_q == ST_RUN);

  // ==========================================================
  // Reset sequencing and option byte
  // ==========================================================
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q  <= ST_HOLD;
      optCnt_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        ST_HOLD:
        begin
          optCnt_q <= 4'h0;
          if (rstPinSync)
            state_q <= ST_OPT;
        end
        ST_OPT:
        begin
          if (!rstPinSync)
            optCnt_q <= 4'h0;
          else if (optCnt_q == OPT_READ_CYCLES - 4'h1)
            state_q <= ST_RUN;
          else
            optCnt_q <= optCnt_q + 4'h1;
        end
        ST_RUN:
        begin
          optCnt_q <= 4'h0;
          if (optIsReset_q && !rstPinSync)
            state_q <= ST_HOLD;
        end
        default:
          state_q <= ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      optIsReset_q <= 1'b1;
    else if (state_q == ST_OPT && rstPinSync
             && optCnt_q == OPT_READ_CYCLES - 4'h1)
      optIsReset_q <= optionByte[OPT_RESET_FN_BIT];
  end

  // ==========================================================
  // Reset outputs and pull-downs
  // ==========================================================
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      coreRstN                     <= 1'b0;
      osc_out_analog_shared_pin_pd <= 1'b1;
      osc_in_analog_shared_pin_pd  <= 1'b1;
    end
    else
    begin
      coreRstN                     <= running;
      osc_out_analog_shared_pin_pd <= !running;
      osc_in_analog_shared_pin_pd  <= !running;
    end
  end

  // ==========================================================
  // APB decode
  // ==========================================================
  assign access = psel && penable;
  assign wrEn   = access && pwrite && pready && running;
  assign mapped = (paddr == OFF_DATA) || (paddr == OFF_MODE)
               || (paddr == OFF_BITOP) || (paddr == OFF_IRQ_FLAG)
               || (paddr == OFF_IRQ_MASK) || (paddr == OFF_STATUS);

  // Byte as seen by a port read: pin for inputs, latch for outputs
  assign portView = (pinSync & mode_q) | (latch_q & ~mode_q);
  assign bitIdx   = pwdata[BITOP_IDX_LSB +: 3];

  always_comb
  begin
    rmwByte         = portView;
    rmwByte[bitIdx] = pwdata[BITOP_VAL_BIT];
  end

  always_comb
  begin
    rdMux = '0;
    case (paddr)
      OFF_DATA:     rdMux[PORT_W-1:0] = portView;
      OFF_MODE:     rdMux[PORT_W-1:0] = mode_q;
      OFF_IRQ_FLAG: rdMux[1:0] = flag_q;
      OFF_IRQ_MASK: rdMux[1:0] = mask_q;
      OFF_STATUS:
      begin
        rdMux[STAT_RUN_BIT]   = running;
        rdMux[STAT_RSTFN_BIT] = optIsReset_q;
        rdMux[STAT_PIN_BIT]   = rstPinSync;
      end
      default:      rdMux = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access && !pready;
      prdata  <= (access && !pready && !pwrite) ? rdMux : '0;
      pslverr <= access && !pready && !mapped;
    end
  end

  // ==========================================================
  // Port latch and mode
  // ==========================================================
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      latch_q <= LATCH_RST;
    else if (!running)
      latch_q <= LATCH_RST;
    else if (wrEn && paddr == OFF_DATA)
      latch_q <= pwdata[PORT_W-1:0];
    else if (wrEn && paddr == OFF_BITOP)
      latch_q <= rmwByte;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      mode_q <= MODE_RST;
    else if (!running)
      mode_q <= MODE_RST;
    else if (wrEn && paddr == OFF_MODE)
      mode_q <= pwdata[PORT_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      padOut <= LATCH_RST;
      padOe  <= '0;
    end
    else
    begin
      padOut <= latch_q;
      padOe  <= running ? ~mode_q : '0;
    end
  end

  // ==========================================================
  // External interrupt flags
  // ==========================================================
  assign effLvl  = {portView[IRQ_B_PORT_BIT], portView[IRQ_A_PORT_BIT]};
  assign irqEdge = running ? (effLvl ^ prevLvl_q) : 2'h0;
  assign flagClr = (wrEn && paddr == OFF_IRQ_FLAG) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      prevLvl_q <= 2'h3;
    else
      prevLvl_q <= effLvl;
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      flag_q <= FLAG_RST;
    else if (!running)
      flag_q <= FLAG_RST;
    else
      flag_q <= (flag_q & ~flagClr) | irqEdge;
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      mask_q <= MASK_RST;
    else if (!running)
      mask_q <= MASK_RST;
    else if (wrEn && paddr == OFF_IRQ_MASK)
      mask_q <= pwdata[1:0];
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      irqRequest <= 2'h0;
    else
      irqRequest <= flag_q & ~mask_q;
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_pulldown;
    @(posedge sys_clk) disable iff (!nrst)
    !running |=> osc_out_analog_shared_pin_pd && osc_in_analog_shared_pin_pd
                 && !coreRstN;
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("pull-downs not active in reset");
  property p_port_mode_no_reset;
    @(posedge sys_clk) disable iff (!nrst)
    running && !optIsReset_q |=> running;
  endproperty
  a_port_mode_no_reset: assert property (p_port_mode_no_reset)
    else $error("port-mode pin caused a reset");
  property p_reset_mode;
    @(posedge sys_clk) disable iff (!nrst)
    running && optIsReset_q && !rstPinSync
      |=> state_q == ST_HOLD ##1 !coreRstN;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("reset pin low did not reset");
  property p_opt_hold;
    @(posedge sys_clk) disable iff (!nrst)
    state_q == ST_OPT && !rstPinSync |=> state_q == ST_OPT && optCnt_q == 4'h0;
  endproperty
  a_opt_hold: assert property (p_opt_hold)
    else $error("reset released while pin low");
  property p_opt_len;
    @(posedge sys_clk) disable iff (!nrst)
    $rose(running) |-> $past(state_q, 4) == ST_OPT;
  endproperty
  a_opt_len: assert property (p_opt_len)
    else $error("option read too short");
  property p_irq_edge;
    @(posedge sys_clk) disable iff (!nrst)
    running && $changed(latch_q[IRQ_A_PORT_BIT]) && !mode_q[IRQ_A_PORT_BIT]
      && $stable(mode_q) ##0 !flagClr[0] |=> flag_q[0];
  endproperty
  a_irq_edge: assert property (p_irq_edge)
    else $error("output change did not set flag");
  property p_flag_sticky;
    @(posedge sys_clk) disable iff (!nrst)
    running && flag_q[1] && !flagClr[1] |=> flag_q[1] || !running;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag lost without clear");
  property p_mask_gate;
    @(posedge sys_clk) disable iff (!nrst)
    flag_q[0] && mask_q[0] |=> !irqRequest[0];
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("masked flag raised request");
  property p_bitop;
    @(posedge sys_clk) disable iff (!nrst)
    running && wrEn && paddr == OFF_BITOP |=> latch_q == $past(rmwByte)
      ##1 padOut == $past(latch_q);
  endproperty
  a_bitop: assert property (p_bitop)
    else $error("bit write not byte-wide");

endmodule : port_pin_reset

// ### rtl/port_pin_pkg.sv
// Package: register map, field positions, reset values and counts
// for the port pin block; assumes a 32-bit APB with byte addresses.
package port_pin_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // Register byte offsets
  // ==========================================================
  localparam logic [7:0] OFF_DATA     = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_BITOP    = 8'h08;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BITOP_IDX_LSB = 0;
  localparam int BITOP_VAL_BIT = 8;
  localparam int IRQ_A_PORT_BIT = 1;
  localparam int IRQ_B_PORT_BIT = 2;
  localparam int OPT_RESET_FN_BIT = 0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_RSTFN_BIT = 1;
  localparam int STAT_PIN_BIT = 2;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] MODE_RST  = 8'hFF;
  localparam logic [1:0] FLAG_RST  = 2'h0;
  localparam logic [1:0] MASK_RST  = 2'h3;

  // ==========================================================
  // Counts
  // ==========================================================
  localparam logic [3:0] OPT_READ_CYCLES = 4'h4;

endpackage : port_pin_pkg

// ### rtl/port_pin_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent level from outside sys_clk.
`timescale 1ns/100ps
module port_pin_sync #(
  parameter int W = 9
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  // ==========================================================
  // Synchroniser stages
  // ==========================================================
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q  <= '1;
      syncOut <= '1;
    end
    else
    begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : port_pin_sync

// ### verif/port_pin_board.sv
// Board model: pin wiring, external drivers, reset pin pull-up.
// Assumes the device drives a pin wherever its padOe bit is high.
`timescale 1ns/100ps
module port_pin_board (
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] extLvl,
  input  wire logic       pinLow,
  output logic      [7:0] padIn,
  output logic            resetPin
);
  // ==========================================================
  // Pin levels
  // ==========================================================
  // Driven pins follow the device, the rest the board drivers
  assign padIn = (padOe & padOut) | (~padOe & extLvl);
  // Pull-up on the shared reset pin unless a switch grounds it
  assign resetPin = pinLow ? 1'b0 : 1'b1;
endmodule : port_pin_board

// ### verif/port_pin_reset_bench.sv
// Testbench: APB tasks and directed sequences for the port block.
// Assumes the board model in port_pin_board.sv.
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    nTests++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("mismatch %s exp %0h got %0h", nm, e, g); \
    end \
  end
module port_pin_reset_bench;
  import port_pin_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  padIn;
  logic [7:0]  padOut;
  logic [7:0]  padOe;
  logic [7:0]  extLvl = 8'h00;
  logic        pinLow = 1'b0;
  logic        resetPin;
  logic [7:0]  optionByte = 8'h01;
  logic        pdOut;
  logic        pdIn;
  logic        coreRstN;
  logic [1:0]  irqRequest;
  logic [31:0] rd;
  logic        err;
  int          fails = 0;
  int          nTests = 0;

  // ==========================================================
  // Clock, design and board
  // ==========================================================
  always #25 sys_clk = ~sys_clk;

  port_pin_reset port_pin_reset_inst (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .padIn(padIn),
    .padOut(padOut), .padOe(padOe),
    .reset_shared_port_pin(resetPin), .optionByte(optionByte),
    .osc_out_analog_shared_pin_pd(pdOut),
    .osc_in_analog_shared_pin_pd(pdIn), .coreRstN(coreRstN),
    .irqRequest(irqRequest)
  );

  port_pin_board port_pin_board_inst (
    .padOut(padOut), .padOe(padOe), .extLvl(extLvl),
    .pinLow(pinLow), .padIn(padIn), .resetPin(resetPin)
  );

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      `CHK("pready", 1'b1, pready)
  endtask : apb

  task automatic wait_run;
    int n;
    n = 0;
    while (coreRstN !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (2) @(posedge sys_clk);
  endtask : wait_run

  task automatic pulse_reset;
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("pdOut", 1'b1, pdOut)
    `CHK("pdIn", 1'b1, pdIn)
    `CHK("coreRstN", 1'b0, coreRstN)
    nrst <= 1'b1;
  endtask : pulse_reset

  // ==========================================================
  // Watchdog
  // ==========================================================
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end

  // ==========================================================
  // Sequences
  // ==========================================================
  initial
  begin
    repeat (16) @(posedge sys_clk);
    `CHK("pdOut", 1'b1, pdOut)
    pinLow <= 1'b1;
    nrst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    `CHK("coreRstN", 1'b0, coreRstN)
    pinLow <= 1'b0;
    wait_run();
    `CHK("coreRstN", 1'b1, coreRstN)
    `CHK("pd", 2'b00, {pdOut, pdIn})
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("status", 32'h7, rd)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    // Mask stays set before bit 1 becomes an output
    apb(1'b1, OFF_MODE, 32'hFD);
    apb(1'b1, OFF_DATA, 32'h02);
    repeat (3) @(posedge sys_clk);
    `CHK("irqRequest", 2'b00, irqRequest)
    apb(1'b0, OFF_IRQ_FLAG, 32'h0);
    `CHK("flags", 32'h1, rd)
    apb(1'b1, OFF_IRQ_FLAG, 32'h1);
    apb(1'b0, OFF_IRQ_FLAG, 32'h0);
    `CHK("flags", 32'h0, rd)
    apb(1'b1, OFF_IRQ_MASK, 32'h2);
    apb(1'b1, OFF_DATA, 32'h00);
    repeat (3) @(posedge sys_clk);
    `CHK("irqRequest", 2'b01, irqRequest)
    // Bit write on a mixed port copies input pins into latches
    extLvl <= 8'hA0;
    apb(1'b1, OFF_MODE, 32'hF0);
    apb(1'b1, OFF_BITOP, 32'h100);
    apb(1'b1, OFF_MODE, 32'h00);
    apb(1'b0, OFF_DATA, 32'h0);
    `CHK("data", 32'hA1, rd)
    `CHK("padOut", 8'hA1, padOut)
    `CHK("padOe", 8'hFF, padOe)
    // Second interrupt pin: output change sets its flag, mask holds it
    apb(1'b1, OFF_DATA, 32'hA5);
    apb(1'b0, OFF_IRQ_FLAG, 32'h0);
    `CHK("flags", 32'h3, rd)
    `CHK("irqRequest", 2'b01, irqRequest)
    // Shared pin as reset input
    pinLow <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK("coreRstN", 1'b0, coreRstN)
    `CHK("pdIn", 1'b1, pdIn)
    pinLow <= 1'b0;
    wait_run();
    // Shared pin as input port
    optionByte <= 8'h00;
    pulse_reset();
    wait_run();
    pinLow <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK("coreRstN", 1'b1, coreRstN)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("status", 32'h1, rd)
    wrap_up();
  end
endmodule : port_pin_reset_bench
